/* File: msf_fault_report.v */
// Security fault reporting, drop events, PN update and FCS fault code insertion.
`timescale 1ns/10ps
`include "msf_consts.vh"

// Overview of operation
// [RULE_01] Status bit 0 flags a short protected packet shorter than its length field.
// [RULE_02] Status bits 1 and 14 flag output and fatal internal hardware faults.
// [RULE_03] Status bit 2 flags flow type disagreeing with the record direction.
// [RULE_04] Status bit 3 flags an invalid transform record, such as bad algorithms.
// [RULE_05] Status bit 4 warns that egress sequence number passed the limit; traffic continues.
// [RULE_06] Software reads status for the cause; writing ones clears those bits.
// [RULE_07] Software programs the warning limit and enables its interrupt first.
// [RULE_08] On warning software disables, clears, re-keys, then re-enables the interrupt.
// [RULE_09] Classification drop interrupt fires on a lookup drop action.
// [RULE_10] Consistency check drop interrupt fires on ingress consistency discards only.
// [RULE_11] Post-processing drop interrupt fires on non-MTU post-processing discards.
// [RULE_12] A separate MTU drop interrupt fires on MTU check discards.
// [RULE_13] Host writes target number, context index, then sets update enable.
// [RULE_14] Core raises context number only if lower, then clears the enable.
// [RULE_15] An equal or higher context number stays unchanged.
// [RULE_16] Global and association masks choose which events count as security failures.
// [RULE_17] With debug on, a failing frame carries a fault code with failing bit 31.
// [RULE_18] Bit 30 marks association hit; then bits 29:24 hold the pointer.
// [RULE_19] Without a hit, bits 25:24 give tag class; bit 26 marks control.
// [RULE_20] Bits 23:10 carry global events, bits 9:0 association events.
// [RULE_21] Ingress global vector positions 0 to 17 follow the fixed order.
// [RULE_22] Ingress association vector positions 0 to 12 follow the fixed order.
// [RULE_23] Egress global vector uses positions 0 to 8; 13:9 read zero.
// [RULE_24] Egress association vector uses positions 0 to 5; the rest read zero.
module msf_fault_report (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire [`MSF_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_err_input,
  input wire i_err_output,
  input wire i_err_proc,
  input wire i_err_context,
  input wire i_err_fatal,
  input wire i_egr_seq_valid,
  input wire [31:0] i_egr_seq,
  input wire i_ingress,
  input wire i_drop_class,
  input wire i_drop_consist,
  input wire i_drop_post,
  input wire i_drop_mtu,
  output reg o_crypto_irq,
  output reg o_drop_class_irq,
  output reg o_drop_consist_irq,
  output reg o_drop_post_irq,
  output reg o_drop_mtu_irq,
  input wire i_ctx_rd_valid,
  input wire [63:0] i_ctx_rd_pn,
  input wire i_ctx_wr_done,
  output reg o_ctx_rd_req,
  output reg o_ctx_wr_req,
  output reg [`MSF_CTX_W-1:0] o_ctx_index,
  output reg [63:0] o_ctx_wr_pn,
  input wire i_frm_valid,
  input wire i_frm_egress,
  input wire i_frm_sa_hit,
  input wire [`MSF_CTX_W-1:0] i_frm_sa_ptr,
  input wire i_frm_ctrl,
  input wire [1:0] i_frm_tag_class,
  input wire [`MSF_GLB_W-1:0] i_frm_glb_evt,
  input wire [`MSF_SA_W-1:0] i_frm_sa_evt,
  input wire [31:0] i_frm_fcs,
  output reg o_fcs_valid,
  output reg [31:0] o_fcs,
  output reg o_secfail
);
  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [31:0] crypto_error_status;
  reg [31:0] crypto_irq_enable;
  reg [31:0] seqnum_warn_limit;
  reg [31:0] target_pn_low;
  reg [31:0] target_pn_high;
  reg [`MSF_CTX_W-1:0] target_context_index;
  reg pn_xpn;
  reg [`MSF_GLB_W-1:0] global_fail_event_mask;
  reg [`MSF_SA_W-1:0] assoc_fail_event_mask;
  reg debug_enable;
  reg [3:0] drop_event_status;
  reg [31:0] last_fault_code;

  // --------------------------------------------------------------------
  // Event decode
  // --------------------------------------------------------------------
  reg [31:0] next_crypto_error_status;
  reg [3:0] next_drop_event_status;
  reg [31:0] crypto_set;
  reg [3:0] drop_set;
  wire wr_status;
  wire wr_drop;
  wire pnu_start;
  wire pnu_busy;
  wire pnu_rd_req;
  wire pnu_wr_req;
  wire [`MSF_CTX_W-1:0] pnu_ctx_index;
  wire [63:0] pnu_wr_pn;
  wire [31:0] fault_code;
  wire frm_secfail;

  assign wr_status = i_wr && (i_addr == `MSF_OFS_CRYPTO_ERROR_STATUS);
  assign wr_drop = i_wr && (i_addr == `MSF_OFS_DROP_EVENT_STATUS);
  // A write of the enable bit while an update runs is ignored.
  assign pnu_start = i_wr && (i_addr == `MSF_OFS_PN_UPDATE_CTRL)
                     && i_wdata[`MSF_PNU_ENABLE] && !pnu_busy; // [RULE_13]

  always @* begin
    crypto_set = 32'h00000000;
    crypto_set[`MSF_ST_INPUT] = i_err_input; // [RULE_01]
    crypto_set[`MSF_ST_OUTPUT] = i_err_output; // [RULE_02]
    crypto_set[`MSF_ST_FATAL] = i_err_fatal; // [RULE_02]
    crypto_set[`MSF_ST_PROC] = i_err_proc; // [RULE_03]
    crypto_set[`MSF_ST_CONTEXT] = i_err_context; // [RULE_04]
    // Only a warning: nothing here touches the frame path.
    crypto_set[`MSF_ST_SEQ_THR] = i_egr_seq_valid && (i_egr_seq > seqnum_warn_limit); // [RULE_05]
    drop_set = 4'h0;
    drop_set[`MSF_DROP_CLASS] = i_drop_class; // [RULE_09]
    drop_set[`MSF_DROP_CONSIST] = i_drop_consist && i_ingress; // [RULE_10]
    drop_set[`MSF_DROP_POST] = i_drop_post; // [RULE_11]
    drop_set[`MSF_DROP_MTU] = i_drop_mtu; // [RULE_12]
  end

  // --------------------------------------------------------------------
  // Sticky status with write-one-to-clear
  // --------------------------------------------------------------------
  always @* begin
    next_crypto_error_status = crypto_error_status;
    next_drop_event_status = drop_event_status;
    // A clear and a new event in the same cycle keep the bit set.
    if (wr_status) begin
      next_crypto_error_status = crypto_error_status & ~i_wdata; // [RULE_06]
    end
    if (wr_drop) begin
      next_drop_event_status = drop_event_status & ~i_wdata[3:0];
    end
    next_crypto_error_status = (next_crypto_error_status | crypto_set) & `MSF_ST_IMPL_MASK;
    next_drop_event_status = next_drop_event_status | drop_set;
  end

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      crypto_error_status <= 32'h00000000;
      drop_event_status <= 4'h0;
    end else begin
      crypto_error_status <= next_crypto_error_status; // [RULE_06]
      drop_event_status <= next_drop_event_status;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      crypto_irq_enable <= `MSF_RST_IRQ_ENABLE;
      seqnum_warn_limit <= `MSF_RST_SEQNUM_WARN_LIMIT;
      target_pn_low <= 32'h00000000;
      target_pn_high <= 32'h00000000;
      target_context_index <= {`MSF_CTX_W{1'b0}};
      pn_xpn <= 1'b0;
      global_fail_event_mask <= {`MSF_GLB_W{1'b0}};
      assoc_fail_event_mask <= {`MSF_SA_W{1'b0}};
      debug_enable <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        `MSF_OFS_CRYPTO_IRQ_ENABLE: begin
          crypto_irq_enable <= i_wdata & `MSF_ST_IMPL_MASK;
        end
        `MSF_OFS_SEQNUM_WARN_LIMIT: begin
          seqnum_warn_limit <= i_wdata;
        end
        `MSF_OFS_TARGET_PN_LOW: begin
          target_pn_low <= i_wdata;
        end
        `MSF_OFS_TARGET_PN_HIGH: begin
          target_pn_high <= i_wdata;
        end
        `MSF_OFS_TARGET_CONTEXT_INDEX: begin
          target_context_index <= i_wdata[`MSF_CTX_W-1:0];
        end
        `MSF_OFS_PN_UPDATE_CTRL: begin
          pn_xpn <= i_wdata[`MSF_PNU_XPN];
        end
        `MSF_OFS_GLOBAL_FAIL_EVENT_MASK: begin
          global_fail_event_mask <= i_wdata[`MSF_GLB_W-1:0]; // [RULE_16]
        end
        `MSF_OFS_ASSOC_FAIL_EVENT_MASK: begin
          assoc_fail_event_mask <= i_wdata[`MSF_SA_W-1:0]; // [RULE_16]
        end
        `MSF_OFS_DEBUG_CTRL: begin
          debug_enable <= i_wdata[0];
        end
        default: begin
          debug_enable <= debug_enable;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Register reads, data in the cycle after the strobe
  // --------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `MSF_OFS_CRYPTO_ERROR_STATUS: o_rdata <= crypto_error_status; // [RULE_06]
        `MSF_OFS_CRYPTO_IRQ_ENABLE: o_rdata <= crypto_irq_enable;
        `MSF_OFS_SEQNUM_WARN_LIMIT: o_rdata <= seqnum_warn_limit;
        `MSF_OFS_TARGET_PN_LOW: o_rdata <= target_pn_low;
        `MSF_OFS_TARGET_PN_HIGH: o_rdata <= target_pn_high;
        `MSF_OFS_TARGET_CONTEXT_INDEX: o_rdata <= {26'h0000000, target_context_index};
        `MSF_OFS_PN_UPDATE_CTRL: o_rdata <= {30'h00000000, pn_xpn, pnu_busy}; // [RULE_14]
        `MSF_OFS_GLOBAL_FAIL_EVENT_MASK: o_rdata <= {14'h0000, global_fail_event_mask};
        `MSF_OFS_ASSOC_FAIL_EVENT_MASK: o_rdata <= {19'h00000, assoc_fail_event_mask};
        `MSF_OFS_DEBUG_CTRL: o_rdata <= {31'h00000000, debug_enable};
        `MSF_OFS_DROP_EVENT_STATUS: o_rdata <= {28'h0000000, drop_event_status};
        `MSF_OFS_LAST_FAULT_CODE: o_rdata <= last_fault_code;
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt outputs
  // --------------------------------------------------------------------
  // Outputs follow the next status value so they line up with the status register.
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_crypto_irq <= 1'b0;
      o_drop_class_irq <= 1'b0;
      o_drop_consist_irq <= 1'b0;
      o_drop_post_irq <= 1'b0;
      o_drop_mtu_irq <= 1'b0;
    end else begin
      o_crypto_irq <= |(next_crypto_error_status & crypto_irq_enable);
      o_drop_class_irq <= next_drop_event_status[`MSF_DROP_CLASS]; // [RULE_09]
      o_drop_consist_irq <= next_drop_event_status[`MSF_DROP_CONSIST]; // [RULE_10]
      o_drop_post_irq <= next_drop_event_status[`MSF_DROP_POST]; // [RULE_11]
      o_drop_mtu_irq <= next_drop_event_status[`MSF_DROP_MTU]; // [RULE_12]
    end
  end

  // --------------------------------------------------------------------
  // Next packet number update
  // --------------------------------------------------------------------
  msf_pn_update u_pn_update (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_start(pnu_start),
    .i_xpn(i_wdata[`MSF_PNU_XPN]),
    .i_pn_low(target_pn_low),
    .i_pn_high(target_pn_high),
    .i_ctx_index(target_context_index),
    .i_rd_valid(i_ctx_rd_valid),
    .i_rd_pn(i_ctx_rd_pn),
    .i_wr_done(i_ctx_wr_done),
    .o_busy(pnu_busy),
    .o_rd_req(pnu_rd_req),
    .o_wr_req(pnu_wr_req),
    .o_ctx_index(pnu_ctx_index),
    .o_wr_pn(pnu_wr_pn),
    .o_raised()
  );

  always @* begin
    o_ctx_rd_req = pnu_rd_req;
    o_ctx_wr_req = pnu_wr_req;
    o_ctx_index = pnu_ctx_index;
    o_ctx_wr_pn = pnu_wr_pn;
  end

  // --------------------------------------------------------------------
  // Security failure and FCS fault code
  // --------------------------------------------------------------------
  assign frm_secfail = |(i_frm_glb_evt & global_fail_event_mask)
                       || |(i_frm_sa_evt & assoc_fail_event_mask); // [RULE_16]

  msf_fault_code u_fault_code (
    .i_egress(i_frm_egress),
    .i_sa_hit(i_frm_sa_hit),
    .i_sa_ptr(i_frm_sa_ptr),
    .i_ctrl_frame(i_frm_ctrl),
    .i_tag_class(i_frm_tag_class),
    .i_glb_evt(i_frm_glb_evt),
    .i_sa_evt(i_frm_sa_evt),
    .i_fcs_msb(i_frm_fcs[31]),
    .o_code(fault_code)
  );

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fcs_valid <= 1'b0;
      o_fcs <= 32'h00000000;
      o_secfail <= 1'b0;
      last_fault_code <= 32'h00000000;
    end else begin
      o_fcs_valid <= i_frm_valid;
      o_secfail <= i_frm_valid && frm_secfail;
      if (i_frm_valid && frm_secfail && debug_enable) begin
        o_fcs <= fault_code; // [RULE_17]
        last_fault_code <= fault_code;
      end else if (i_frm_valid) begin
        o_fcs <= i_frm_fcs;
      end
    end
  end
endmodule // msf_fault_report

/* File: msf_consts.vh */
// Constants for the fault reporting and drop event block.
`ifndef MSF_CONSTS_VH
`define MSF_CONSTS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MSF_ADDR_W 8
`define MSF_OFS_CRYPTO_ERROR_STATUS 8'h00
`define MSF_OFS_CRYPTO_IRQ_ENABLE 8'h04
`define MSF_OFS_SEQNUM_WARN_LIMIT 8'h08
`define MSF_OFS_TARGET_PN_LOW 8'h0C
`define MSF_OFS_TARGET_PN_HIGH 8'h10
`define MSF_OFS_TARGET_CONTEXT_INDEX 8'h14
`define MSF_OFS_PN_UPDATE_CTRL 8'h18
`define MSF_OFS_GLOBAL_FAIL_EVENT_MASK 8'h1C
`define MSF_OFS_ASSOC_FAIL_EVENT_MASK 8'h20
`define MSF_OFS_DEBUG_CTRL 8'h24
`define MSF_OFS_DROP_EVENT_STATUS 8'h28
`define MSF_OFS_LAST_FAULT_CODE 8'h2C
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MSF_ST_INPUT 0
`define MSF_ST_OUTPUT 1
`define MSF_ST_PROC 2
`define MSF_ST_CONTEXT 3
`define MSF_ST_SEQ_THR 4
`define MSF_ST_FATAL 14
`define MSF_ST_IMPL_MASK 32'h0000401F
`define MSF_DROP_CLASS 0
`define MSF_DROP_CONSIST 1
`define MSF_DROP_POST 2
`define MSF_DROP_MTU 3
`define MSF_PNU_ENABLE 0
`define MSF_PNU_XPN 1
`define MSF_FC_RSVD 31
`define MSF_FC_HIT 30
`define MSF_FC_CTRL 26
`define MSF_GLB_W 18
`define MSF_SA_W 13
`define MSF_CTX_W 6
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MSF_RST_SEQNUM_WARN_LIMIT 32'hF0000000
`define MSF_RST_IRQ_ENABLE 32'h00000000
`endif

/* File: msf_fault_code.v */
// Packs the 32-bit debug fault code that replaces the FCS of a failing frame.
`timescale 1ns/10ps
`include "msf_consts.vh"
module msf_fault_code (
  input wire i_egress,
  input wire i_sa_hit,
  input wire [`MSF_CTX_W-1:0] i_sa_ptr,
  input wire i_ctrl_frame,
  input wire [1:0] i_tag_class,
  input wire [`MSF_GLB_W-1:0] i_glb_evt,
  input wire [`MSF_SA_W-1:0] i_sa_evt,
  input wire i_fcs_msb,
  output reg [31:0] o_code
);
  reg [13:0] glb_field;
  reg [9:0] sa_field;
  reg [5:0] id_field;

  always @* begin
    // Egress global vector uses 9 positions; the rest reads as zero.
    if (i_egress) begin
      glb_field = {5'h00, i_glb_evt[8:0]}; // [RULE_23]
      sa_field = {4'h0, i_sa_evt[5:0]}; // [RULE_24]
    end else begin
      // Ingress vectors are wider than the fields; the low positions are kept.
      glb_field = i_glb_evt[13:0]; // [RULE_21]
      sa_field = i_sa_evt[9:0]; // [RULE_22]
    end
    if (i_sa_hit) begin
      id_field = i_sa_ptr; // [RULE_18]
    end else begin
      id_field = {3'h0, i_ctrl_frame, i_tag_class}; // [RULE_19]
    end
    // Inverting the true top bit guarantees a receiver FCS mismatch.
    o_code = {~i_fcs_msb, i_sa_hit, id_field, glb_field, sa_field}; // [RULE_17] [RULE_20]
  end
endmodule // msf_fault_code

/* File: msf_pn_update.v */
// Ingress next packet number update sequencer toward the context store.
`timescale 1ns/10ps
`include "msf_consts.vh"
module msf_pn_update (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_start,
  input wire i_xpn,
  input wire [31:0] i_pn_low,
  input wire [31:0] i_pn_high,
  input wire [`MSF_CTX_W-1:0] i_ctx_index,
  input wire i_rd_valid,
  input wire [63:0] i_rd_pn,
  input wire i_wr_done,
  output reg o_busy,
  output reg o_rd_req,
  output reg o_wr_req,
  output reg [`MSF_CTX_W-1:0] o_ctx_index,
  output reg [63:0] o_wr_pn,
  output reg o_raised
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_READ = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;
  reg [1:0] state;
  reg xpn;
  wire [63:0] cur_pn;

  assign cur_pn = xpn ? i_rd_pn : {32'h00000000, i_rd_pn[31:0]};

  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      o_busy <= 1'b0;
      o_rd_req <= 1'b0;
      o_wr_req <= 1'b0;
      o_ctx_index <= {`MSF_CTX_W{1'b0}};
      o_wr_pn <= 64'h0000000000000000;
      o_raised <= 1'b0;
      xpn <= 1'b0;
    end else begin
      o_raised <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            o_busy <= 1'b1;
            o_rd_req <= 1'b1;
            o_ctx_index <= i_ctx_index;
            xpn <= i_xpn;
            o_wr_pn <= i_xpn ? {i_pn_high, i_pn_low} : {32'h00000000, i_pn_low}; // [RULE_13]
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (i_rd_valid) begin
            o_rd_req <= 1'b0;
            if (cur_pn < o_wr_pn) begin
              o_wr_req <= 1'b1; // [RULE_14]
              state <= ST_WRITE;
            end else begin
              o_busy <= 1'b0; // [RULE_15]
              state <= ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          if (i_wr_done) begin
            o_wr_req <= 1'b0;
            o_busy <= 1'b0; // [RULE_14]
            o_raised <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // msf_pn_update

/* File: msf_fault_report_assertions.sv */
// Port checker for the fault reporting block.
`timescale 1ns/10ps
module msf_fault_report_assertions (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire i_wr,
  input wire i_ingress,
  input wire i_drop_consist,
  input wire i_drop_mtu,
  input wire o_drop_consist_irq,
  input wire o_drop_mtu_irq,
  input wire i_ctx_rd_valid,
  input wire i_ctx_wr_done,
  input wire o_ctx_rd_req,
  input wire o_ctx_wr_req,
  input wire i_frm_valid,
  input wire o_fcs_valid,
  input wire o_secfail
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_mtu_set; i_drop_mtu |=> o_drop_mtu_irq; endproperty
  a_mtu_set: assert property (p_mtu_set) else $error("mtu irq missing");
  property p_mtu_hold; o_drop_mtu_irq && !i_wr |=> o_drop_mtu_irq; endproperty
  a_mtu_hold: assert property (p_mtu_hold) else $error("mtu irq lost");
  property p_cons_set; i_drop_consist && i_ingress |=> o_drop_consist_irq; endproperty
  a_cons_set: assert property (p_cons_set) else $error("consist irq missing");
  property p_cons_only;
    !o_drop_consist_irq && !(i_drop_consist && i_ingress) |=> !o_drop_consist_irq;
  endproperty
  a_cons_only: assert property (p_cons_only) else $error("consist irq spurious");
  property p_frm_ans; i_frm_valid |=> o_fcs_valid; endproperty
  a_frm_ans: assert property (p_frm_ans) else $error("frame answer missing");
  property p_frm_idle; !i_frm_valid |=> !o_fcs_valid && !o_secfail; endproperty
  a_frm_idle: assert property (p_frm_idle) else $error("frame pulse spurious");
  property p_rdreq_hold; o_ctx_rd_req && !i_ctx_rd_valid |=> o_ctx_rd_req; endproperty
  a_rdreq_hold: assert property (p_rdreq_hold) else $error("read request dropped");
  property p_wr_after; $rose(o_ctx_wr_req) |-> $past(i_ctx_rd_valid); endproperty
  a_wr_after: assert property (p_wr_after) else $error("write without read");
  property p_wr_end; o_ctx_wr_req && i_ctx_wr_done |=> !o_ctx_wr_req; endproperty
  a_wr_end: assert property (p_wr_end) else $error("write request stuck");
  c_wr: cover property (o_ctx_wr_req && i_ctx_wr_done);
  c_fail: cover property (o_secfail);
  c_cons: cover property (o_drop_consist_irq);
endmodule // msf_fault_report_assertions
bind msf_fault_report msf_fault_report_assertions u_chk (.*);

/* File: tb_top.sv */
// Self-checking testbench for the fault reporting block.
`timescale 1ns/10ps
`include "msf_consts.vh"
module tb_top;
  reg i_ref_clk = 1'b0;
  reg i_rstn = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [4:0] err_ev = 5'h00;
  reg [3:0] drop_ev = 4'h0;
  reg i_egr_seq_valid = 1'b0;
  reg [31:0] i_egr_seq = 32'h0;
  reg i_ingress = 1'b1;
  reg i_ctx_rd_valid = 1'b0;
  reg [63:0] i_ctx_rd_pn = 64'h0;
  reg i_ctx_wr_done = 1'b0;
  reg i_frm_valid = 1'b0;
  reg i_frm_egress = 1'b0;
  reg i_frm_sa_hit = 1'b0;
  reg [5:0] i_frm_sa_ptr = 6'h00;
  reg i_frm_ctrl = 1'b0;
  reg [1:0] i_frm_tag_class = 2'h0;
  reg [17:0] i_frm_glb_evt = 18'h0;
  reg [12:0] i_frm_sa_evt = 13'h0;
  reg [31:0] i_frm_fcs = 32'h0;
  wire [31:0] o_rdata;
  wire o_crypto_irq;
  wire o_drop_class_irq;
  wire o_drop_consist_irq;
  wire o_drop_post_irq;
  wire o_drop_mtu_irq;
  wire o_ctx_rd_req;
  wire o_ctx_wr_req;
  wire [5:0] o_ctx_index;
  wire [63:0] o_ctx_wr_pn;
  wire o_fcs_valid;
  wire [31:0] o_fcs;
  wire o_secfail;
  wire [3:0] dirq = {o_drop_mtu_irq, o_drop_post_irq, o_drop_consist_irq, o_drop_class_irq};
  integer err_count = 0;
  integer check_count = 0;
  integer seed = 56827;
  integer i;
  reg [63:0] rd_q[$];
  reg [32:0] fcs_q[$];
  reg rd_d = 1'b0;
  reg dbg = 1'b0;
  reg [31:0] lim;
  reg [31:0] last_code;
  msf_fault_report DUT (.*, .i_err_input(err_ev[0]), .i_err_output(err_ev[1]),
    .i_err_proc(err_ev[2]), .i_err_context(err_ev[3]), .i_err_fatal(err_ev[4]),
    .i_drop_class(drop_ev[0]), .i_drop_consist(drop_ev[1]), .i_drop_post(drop_ev[2]),
    .i_drop_mtu(drop_ev[3]));
  always #4 i_ref_clk = ~i_ref_clk;
  // ------------
  // Bench tasks
  // ------------
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Read data stands only the cycle after the strobe.
  always @(posedge i_ref_clk) begin : mon
    reg [63:0] m;
    reg [32:0] f;
    if (rd_d) begin
      m = rd_q.pop_front();
      chk(o_rdata & m[63:32], m[31:0]);
    end
    if (o_fcs_valid) begin
      f = (fcs_q.size() != 0) ? fcs_q.pop_front() : ~{1'b0, o_fcs};
      chk({31'h0, o_secfail}, {31'h0, f[32]});
      chk(o_fcs, f[31:0]);
    end
    rd_d <= i_rd;
  end
  task wr(input [7:0] a, input [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    @(posedge i_ref_clk);
    rd_q.push_back({m, e & m});
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask
  task ev(input [4:0] e, input [3:0] d, input [31:0] sq, input sv);
    @(posedge i_ref_clk);
    err_ev <= e;
    drop_ev <= d;
    i_egr_seq <= sq;
    i_egr_seq_valid <= sv;
    @(posedge i_ref_clk);
    err_ev <= 5'h00;
    drop_ev <= 4'h0;
    i_egr_seq_valid <= 1'b0;
    i_egr_seq <= ~sq;
    #1;
  endtask
  task pn_run(input xpn, input [63:0] cur, input [63:0] tgt);
    reg [63:0] e, c;
    reg [5:0] ctx;
    integer n;
    begin
      e = xpn ? tgt : {32'h0, tgt[31:0]};
      c = xpn ? cur : {32'h0, cur[31:0]};
      ctx = $random(seed);
      wr(`MSF_OFS_TARGET_PN_LOW, tgt[31:0]);
      wr(`MSF_OFS_TARGET_PN_HIGH, tgt[63:32]);
      wr(`MSF_OFS_TARGET_CONTEXT_INDEX, {26'h0, ctx});
      wr(`MSF_OFS_PN_UPDATE_CTRL, {30'h0, xpn, 1'b1});
      n = 0;
      @(negedge i_ref_clk);
      while (o_ctx_rd_req !== 1'b1 && n < 20) begin
        @(negedge i_ref_clk);
        n = n + 1;
      end
      chk({26'h0, o_ctx_index}, {26'h0, ctx});
      @(posedge i_ref_clk);
      i_ctx_rd_valid <= 1'b1;
      i_ctx_rd_pn <= cur;
      @(posedge i_ref_clk);
      i_ctx_rd_valid <= 1'b0;
      i_ctx_rd_pn <= ~cur;
      @(negedge i_ref_clk);
      chk({31'h0, o_ctx_wr_req}, {31'h0, c < e});
      if (c < e) begin
        chk(o_ctx_wr_pn[31:0], e[31:0]);
        chk(o_ctx_wr_pn[63:32], e[63:32]);
        @(posedge i_ref_clk);
        i_ctx_wr_done <= 1'b1;
        @(posedge i_ref_clk);
        i_ctx_wr_done <= 1'b0;
      end
      repeat (3) @(posedge i_ref_clk);
      rd(`MSF_OFS_PN_UPDATE_CTRL, 32'h1, 32'h0);
    end
  endtask
  task frame(input sf);
    reg [63:0] r;
    reg [31:0] fc;
    begin
      r = {$random(seed), $random(seed)};
      fc = $random(seed);
      r[11] = 1'b1;
      last_code = {~fc[31], r[1], r[1] ? r[7:2] : {3'h0, r[8], r[10:9]},
        r[0] ? {5'h0, r[19:11]} : r[24:11], r[0] ? {4'h0, r[34:29]} : r[38:29]};
      fcs_q.push_back({sf, (sf && dbg) ? last_code : fc});
      @(posedge i_ref_clk);
      i_frm_valid <= 1'b1;
      i_frm_egress <= r[0];
      i_frm_sa_hit <= r[1];
      i_frm_sa_ptr <= r[7:2];
      i_frm_ctrl <= r[8];
      i_frm_tag_class <= r[10:9];
      i_frm_glb_evt <= r[28:11];
      i_frm_sa_evt <= r[41:29];
      i_frm_fcs <= fc;
    end
  endtask
  // ---------------
  // Main sequence
  // ---------------
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(`MSF_OFS_SEQNUM_WARN_LIMIT, 32'hFFFFFFFF, 32'hF0000000);
    rd(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'hFFFFFFFF, 32'h0);
    rd(`MSF_OFS_DROP_EVENT_STATUS, 32'hFFFFFFFF, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'hFFFFFFFF, 32'h0);
    $display("reset test done");
    wr(`MSF_OFS_CRYPTO_IRQ_ENABLE, 32'h0000401F);
    for (i = 0; i < 5; i = i + 1) begin
      ev(5'h01 << i, 4'h0, 32'h0, 1'b0);
      chk({31'h0, o_crypto_irq}, 32'h1);
      lim = (i == 4) ? 32'h4000 : (32'h1 << i);
      rd(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'hFFFFFFFF, lim);
      wr(`MSF_OFS_CRYPTO_ERROR_STATUS, lim);
      rd(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'hFFFFFFFF, 32'h0);
    end
    chk({31'h0, o_crypto_irq}, 32'h0);
    $display("crypto test done");
    lim = $random(seed);
    lim[31] = 1'b0;
    wr(`MSF_OFS_SEQNUM_WARN_LIMIT, lim);
    ev(5'h00, 4'h0, lim, 1'b1);
    rd(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'hFFFFFFFF, 32'h0);
    ev(5'h00, 4'h0, lim + 32'h1, 1'b1);
    chk({31'h0, o_crypto_irq}, 32'h1);
    wr(`MSF_OFS_CRYPTO_IRQ_ENABLE, 32'h0000400F);
    @(posedge i_ref_clk);
    #1;
    chk({31'h0, o_crypto_irq}, 32'h0);
    rd(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'hFFFFFFFF, 32'h10);
    wr(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'h10);
    rd(`MSF_OFS_CRYPTO_ERROR_STATUS, 32'hFFFFFFFF, 32'h0);
    $display("seq warn test done");
    for (i = 0; i < 4; i = i + 1) begin
      ev(5'h00, 4'h1 << i, 32'h0, 1'b0);
      chk({28'h0, dirq}, 32'h1 << i);
      rd(`MSF_OFS_DROP_EVENT_STATUS, 32'hF, 32'h1 << i);
      wr(`MSF_OFS_DROP_EVENT_STATUS, 32'h1 << i);
      #1;
      chk({28'h0, dirq}, 32'h0);
    end
    i_ingress <= 1'b0;
    ev(5'h00, 4'h2, 32'h0, 1'b0);
    chk({28'h0, dirq}, 32'h0);
    i_ingress <= 1'b1;
    $display("drop test done");
    pn_run(1'b0, 64'h5, 64'h100);
    pn_run(1'b0, 64'h100, 64'h100);
    pn_run(1'b0, 64'h200, 64'h100);
    pn_run(1'b0, 64'hFFFF_0000_0005, 64'h9);
    pn_run(1'b1, 64'h1_0000_0000, 64'h2_0000_0005);
    pn_run(1'b1, 64'h3_0000_0000, 64'h2_0000_0005);
    $display("pn test done");
    wr(`MSF_OFS_GLOBAL_FAIL_EVENT_MASK, 32'h3FFFF);
    wr(`MSF_OFS_ASSOC_FAIL_EVENT_MASK, 32'h1FFF);
    wr(`MSF_OFS_DEBUG_CTRL, 32'h1);
    dbg = 1'b1;
    repeat (12) frame(1'b1);
    @(posedge i_ref_clk);
    i_frm_valid <= 1'b0;
    rd(`MSF_OFS_LAST_FAULT_CODE, 32'hFFFFFFFF, last_code);
    wr(`MSF_OFS_GLOBAL_FAIL_EVENT_MASK, 32'h0);
    wr(`MSF_OFS_ASSOC_FAIL_EVENT_MASK, 32'h0);
    repeat (3) frame(1'b0);
    @(posedge i_ref_clk);
    i_frm_valid <= 1'b0;
    wr(`MSF_OFS_GLOBAL_FAIL_EVENT_MASK, 32'h3FFFF);
    wr(`MSF_OFS_DEBUG_CTRL, 32'h0);
    dbg = 1'b0;
    frame(1'b1);
    @(posedge i_ref_clk);
    i_frm_valid <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    $display("fcs test done");
    final_report;
  end
  // Bound well above the sequence length.
  initial begin
    #160000;
    err_count = err_count + 1;
    final_report;
  end
endmodule // tb_top
